// *** common/bdtc_pkg.sv ***
// Constants and types for the bulk DMA channel with transaction time-out.
package bdtc_pkg;
  localparam int ADDR_W = 2;
  localparam logic [1:0] OFS_CTRL_STATUS = 2'h0;
  localparam logic [1:0] OFS_DEFINITION = 2'h1;
  localparam logic [1:0] OFS_COMPLETION = 2'h2;
  localparam int CS_TIMEOUT_FLAG = 1;
  localparam int CS_TOUT_LO = 2;
  localparam int CS_TOUT_HI = 6;
  localparam int CS_TEN = 7;
  localparam int CD_EDB_HI = 2;
  localparam int CD_XYO = 3;
  localparam int CD_XYI = 4;
  localparam int CD_CNT_EN = 5;
  localparam int CD_INE = 6;
  localparam int CD_EN = 7;
  localparam int CP_OVR = 0;
  localparam int CP_PARTIAL_PACKET_FLAG = 1;
  localparam logic [4:0] TOUT_RESET = 5'h00;
  localparam logic [2:0] EDB_RESET = 3'h0;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [6:0] BLOCK_BYTES = 7'h40;
  localparam logic [5:0] BLOCK_LAST = 6'h3F;
  localparam logic [4:0] TMR_ONE = 5'h01;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_IN_FILL = 5'b00010,
    ST_OUT_WAIT = 5'b00100,
    ST_OUT_FETCH = 5'b01000,
    ST_OUT_SEND = 5'b10000
  } bdtc_state_type;
endpackage

// *** design/bdtc_channel.sv ***
// Bulk DMA channel: X/Y buffer alternation, transaction time-out and completion codes.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module bdtc_channel (
  input wire logic clk,
  input wire logic srst,
  input wire logic [bdtc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  input wire logic dir_in,
  input wire logic sof_pulse,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_error,
  output logic rx_ready_q,
  output logic tx_valid_q,
  output logic [7:0] tx_data_q,
  input wire logic tx_ready,
  input wire logic x_nak,
  input wire logic y_nak,
  input wire logic [6:0] x_count,
  input wire logic [6:0] y_count,
  output logic buf_wr_en_q,
  output logic buf_rd_en_q,
  output logic buf_sel_q,
  output logic [5:0] buf_addr_q,
  output logic [7:0] buf_wr_data_q,
  input wire logic [7:0] buf_rd_data,
  output logic desc_upd_q,
  output logic desc_sel_q,
  output logic [6:0] desc_count_q,
  output logic desc_nak_q,
  output logic [2:0] edb_ptr_q,
  output logic irq_q
);
  import bdtc_pkg::*;

  bdtc_state_type st_q;
  bdtc_state_type st_d;
  logic ten_q;
  logic [4:0] tout_q;
  logic timeout_flag_q;
  logic en_q;
  logic ine_q;
  logic cnt_en_q;
  logic xyi_q;
  logic xyo_q;
  logic ovr_q;
  logic partial_packet_flag_q;
  logic halt_q;
  logic armed_q;
  logic [4:0] tmr_q;
  logic [6:0] byte_cnt_q;
  logic [6:0] out_len_q;
  logic [5:0] out_idx_q;

  wire wr_cs = reg_wr && (reg_addr == OFS_CTRL_STATUS);
  wire wr_cd = reg_wr && (reg_addr == OFS_DEFINITION);
  wire wr_cp = reg_wr && (reg_addr == OFS_COMPLETION);
  wire start = wr_cd && reg_wdata[CD_EN] && !en_q;
  wire in_fill = (st_q == ST_IN_FILL);
  wire out_wait = (st_q == ST_OUT_WAIT);
  wire out_send = (st_q == ST_OUT_SEND);
  wire in_free = xyi_q ? y_nak : x_nak;
  wire in_both_full = !x_nak && !y_nak;
  wire out_ready = xyo_q ? y_nak : x_nak;
  wire out_both_full = x_nak && y_nak;
  wire [6:0] out_avail = xyo_q ? y_count : x_count;
  wire in_take = in_fill && rx_valid && rx_ready_q;
  wire in_block_done = in_take && (byte_cnt_q[5:0] == BLOCK_LAST);
  wire out_take = out_send && tx_valid_q && tx_ready;
  wire [6:0] out_next = {1'b0, out_idx_q} + 7'h01;
  wire out_last = out_take && (out_next == out_len_q);
  wire out_empty = out_wait && out_ready && (out_avail == 7'h00);
  wire out_partial_done = (out_last && (out_len_q < BLOCK_BYTES)) || out_empty;
  wire in_run = dir_in && in_fill && armed_q;
  wire out_run = !dir_in && (st_q != ST_IDLE) && out_both_full;
  wire tmr_tick = sof_pulse && en_q && ten_q && (in_run || out_run);
  wire expire = tmr_tick && (tmr_q <= TMR_ONE);
  wire in_tmo = expire && dir_in;
  wire out_tmo = expire && !dir_in;
  wire rx_err_stop = rx_error && in_fill && en_q;
  wire hw_stop = in_tmo || out_tmo || out_partial_done;
  wire en_d = wr_cd ? reg_wdata[CD_EN] : (en_q && !hw_stop);
  wire in_partial_upd = in_tmo && !in_both_full && (byte_cnt_q != 7'h00);
  wire timeout_flag_set = in_tmo || out_tmo || rx_err_stop;
  wire ovr_set = in_tmo && in_both_full;
  wire ovr_clr = (in_tmo && !in_both_full) || out_tmo || rx_err_stop || start;
  wire byte_moved = in_take || out_take;
  wire [7:0] rd_cs = {ten_q, tout_q, timeout_flag_q, 1'b0};
  wire [7:0] rd_cd = {en_q, ine_q, cnt_en_q, xyi_q, xyo_q, edb_ptr_q};
  wire [7:0] rd_cp = {6'h00, partial_packet_flag_q, ovr_q};
  wire [7:0] rd_mux = (reg_addr == OFS_CTRL_STATUS) ? rd_cs :
                      (reg_addr == OFS_DEFINITION) ? rd_cd :
                      (reg_addr == OFS_COMPLETION) ? rd_cp : READ_ZERO;
  wire rx_ready_d = (st_d == ST_IN_FILL) && !in_block_done && in_free && en_d;

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (en_q && !halt_q) begin
          st_d = dir_in ? ST_IN_FILL : ST_OUT_WAIT;
        end
      end
      ST_IN_FILL: begin
        st_d = ST_IN_FILL;
      end
      ST_OUT_WAIT: begin
        if (out_ready && !out_empty) begin
          st_d = ST_OUT_FETCH;
        end
      end
      ST_OUT_FETCH: begin
        st_d = ST_OUT_SEND;
      end
      ST_OUT_SEND: begin
        if (out_last) begin
          st_d = ST_OUT_WAIT;
        end else if (out_take) begin
          st_d = ST_OUT_FETCH;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    if (!en_q || hw_stop || rx_err_stop || (wr_cd && !reg_wdata[CD_EN])) begin
      st_d = ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= ST_IDLE;
      rx_ready_q <= 1'b0;
      reg_rdata_q <= READ_ZERO;
      irq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      rx_ready_q <= rx_ready_d;
      reg_rdata_q <= reg_rd ? rd_mux : READ_ZERO;
      irq_q <= en_q && !en_d && ine_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ten_q <= 1'b0;
      tout_q <= TOUT_RESET;
      ine_q <= 1'b0;
      cnt_en_q <= 1'b0;
      edb_ptr_q <= EDB_RESET;
      en_q <= 1'b0;
    end else begin
      if (wr_cs) begin
        ten_q <= reg_wdata[CS_TEN];
        tout_q <= reg_wdata[CS_TOUT_HI:CS_TOUT_LO];
      end
      if (wr_cd) begin
        ine_q <= reg_wdata[CD_INE];
        cnt_en_q <= reg_wdata[CD_CNT_EN];
        edb_ptr_q <= reg_wdata[CD_EDB_HI:0];
      end
      en_q <= en_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      timeout_flag_q <= 1'b0;
      ovr_q <= 1'b0;
      partial_packet_flag_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      if (timeout_flag_set) begin
        timeout_flag_q <= 1'b1;
      end else if (out_partial_done) begin
        timeout_flag_q <= 1'b0;
      end else if (wr_cs && reg_wdata[CS_TIMEOUT_FLAG]) begin
        timeout_flag_q <= 1'b0;
      end
      if (ovr_set) begin
        ovr_q <= 1'b1;
      end else if (ovr_clr || (wr_cp && reg_wdata[CP_OVR])) begin
        ovr_q <= 1'b0;
      end
      if (out_partial_done) begin
        partial_packet_flag_q <= 1'b1;
      end else if (start || (wr_cp && reg_wdata[CP_PARTIAL_PACKET_FLAG])) begin
        partial_packet_flag_q <= 1'b0;
      end
      if (rx_err_stop) begin
        halt_q <= 1'b1;
      end else if (start || (wr_cd && !reg_wdata[CD_EN])) begin
        halt_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tmr_q <= TOUT_RESET;
      armed_q <= 1'b0;
    end else begin
      if (start || byte_moved) begin
        tmr_q <= tout_q;
      end else if (tmr_tick && !expire) begin
        tmr_q <= tmr_q - TMR_ONE;
      end
      if (start) begin
        armed_q <= 1'b0;
      end else if (in_take) begin
        armed_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      xyi_q <= 1'b0;
      xyo_q <= 1'b0;
      byte_cnt_q <= 7'h00;
      out_len_q <= 7'h00;
      out_idx_q <= 6'h00;
    end else begin
      if (wr_cd) begin
        xyi_q <= reg_wdata[CD_XYI];
        xyo_q <= reg_wdata[CD_XYO];
      end else begin
        if (in_block_done) begin
          xyi_q <= !xyi_q;
        end
        if (out_last || out_empty) begin
          xyo_q <= !xyo_q;
        end
      end
      if (start || in_block_done || in_tmo) begin
        byte_cnt_q <= 7'h00;
      end else if (in_take) begin
        byte_cnt_q <= byte_cnt_q + 7'h01;
      end
      if (out_wait && out_ready) begin
        out_len_q <= out_avail;
        out_idx_q <= 6'h00;
      end else if (out_take && !out_last) begin
        out_idx_q <= out_next[5:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      buf_wr_en_q <= 1'b0;
      buf_rd_en_q <= 1'b0;
      buf_sel_q <= 1'b0;
      buf_addr_q <= 6'h00;
      buf_wr_data_q <= 8'h00;
    end else begin
      buf_wr_en_q <= in_take;
      buf_rd_en_q <= (st_d == ST_OUT_FETCH);
      if (in_take) begin
        buf_sel_q <= xyi_q;
        buf_addr_q <= byte_cnt_q[5:0];
        buf_wr_data_q <= rx_data;
      end else if (st_d == ST_OUT_FETCH) begin
        buf_sel_q <= xyo_q;
        buf_addr_q <= out_wait ? 6'h00 : out_next[5:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
    end else begin
      if (st_d != ST_OUT_SEND) begin
        tx_valid_q <= 1'b0;
      end else if (out_send && !tx_valid_q) begin
        tx_valid_q <= 1'b1;
        tx_data_q <= buf_rd_data;
      end else if (out_take) begin
        tx_valid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      desc_upd_q <= 1'b0;
      desc_sel_q <= 1'b0;
      desc_count_q <= 7'h00;
      desc_nak_q <= 1'b0;
    end else begin
      desc_upd_q <= in_block_done || in_partial_upd || out_last || out_empty;
      desc_nak_q <= 1'b0;
      if (in_block_done) begin
        desc_sel_q <= xyi_q;
        desc_count_q <= BLOCK_BYTES;
      end else if (in_partial_upd) begin
        desc_sel_q <= xyi_q;
        desc_count_q <= byte_cnt_q;
      end else if (out_last || out_empty) begin
        desc_sel_q <= xyo_q;
        desc_count_q <= out_len_q & {7{!out_empty}};
      end
    end
  end
endmodule
`default_nettype wire

// *** test/bdtc_channel_props.sv ***
// Concurrent checks on the bulk DMA channel ports.
`timescale 1ns/1ps
`default_nettype none
module bdtc_channel_props (
  input wire logic clk,
  input wire logic srst,
  input wire logic [bdtc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic rx_valid,
  input wire logic rx_ready_q,
  input wire logic tx_valid_q,
  input wire logic [7:0] tx_data_q,
  input wire logic tx_ready,
  input wire logic buf_wr_en_q,
  input wire logic buf_rd_en_q,
  input wire logic [5:0] buf_addr_q,
  input wire logic desc_upd_q,
  input wire logic desc_nak_q,
  input wire logic irq_q
);
  import bdtc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_take; rx_valid && rx_ready_q |=> buf_wr_en_q; endproperty
  a_take: assert property (p_take) else $error("no buffer write after take");
  property p_stray; !(rx_valid && rx_ready_q) |=> !buf_wr_en_q; endproperty
  a_stray: assert property (p_stray) else $error("buffer write without take");
  property p_full; buf_wr_en_q && buf_addr_q == BLOCK_LAST |-> !rx_ready_q; endproperty
  a_full: assert property (p_full) else $error("ready after last byte");
  property p_nak; desc_upd_q |-> !desc_nak_q; endproperty
  a_nak: assert property (p_nak) else $error("descriptor nak not cleared");
  property p_hold; tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q); endproperty
  a_hold: assert property (p_hold) else $error("transmit byte not held");
  property p_fetch; buf_rd_en_q |-> ##2 tx_valid_q; endproperty
  a_fetch: assert property (p_fetch) else $error("fetched byte not offered");
  property p_irq; irq_q |=> !irq_q; endproperty
  a_irq: assert property (p_irq) else $error("interrupt longer than a pulse");
  property p_rsv; reg_rd && reg_addr == OFS_CTRL_STATUS |=> !reg_rdata_q[0]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  c_irq: cover property (irq_q);
  c_desc: cover property (desc_upd_q);
  c_tx: cover property (tx_valid_q && tx_ready);
endmodule
bind bdtc_channel bdtc_channel_props chk_u (.clk, .srst, .reg_addr, .reg_rd, .reg_rdata_q,
  .rx_valid, .rx_ready_q, .tx_valid_q, .tx_data_q, .tx_ready, .buf_wr_en_q, .buf_rd_en_q,
  .buf_addr_q, .desc_upd_q, .desc_nak_q, .irq_q);
`default_nettype wire

// *** test/bdtc_buf_model.sv ***
// Buffer memory and descriptor model of the USB buffer manager side.
`timescale 1ns/1ps
`default_nettype none
module bdtc_buf_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic sel,
  input wire logic [5:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  input wire logic upd,
  input wire logic dsel,
  input wire logic [6:0] dcount,
  input wire logic dnak,
  input wire logic [1:0] set_nak,
  input wire logic [6:0] set_cnt,
  output logic x_nak,
  output logic y_nak,
  output logic [6:0] x_count,
  output logic [6:0] y_count
);
  logic [7:0] mem [2][64];
  logic [1:0] nak_q;
  logic [6:0] cnt_q [2];
  assign x_nak = nak_q[0];
  assign y_nak = nak_q[1];
  assign x_count = cnt_q[0];
  assign y_count = cnt_q[1];
  always_ff @(posedge clk) begin
    if (wr_en) mem[sel][addr] <= wr_data;
    if (srst) rd_data <= 8'h00;
    else rd_data <= rd_en ? mem[sel][addr] : ~rd_data;
    if (srst) nak_q <= 2'h0;
    else if (upd) nak_q[dsel] <= dnak;
    else nak_q <= nak_q | set_nak;
    if (upd) cnt_q[dsel] <= dcount;
    for (int i = 0; i < 2; i++) begin
      if (set_nak[i]) cnt_q[i] <= set_cnt;
    end
  end
endmodule
`default_nettype wire

// *** test/bdtc_channel_tb_top.sv ***
// Register-level testbench of the bulk DMA channel.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module bdtc_channel_tb_top;
  import bdtc_pkg::*;
  logic clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, dir_in = 1'b1, sof_pulse = 1'b0;
  logic rx_valid = 1'b0, rx_error = 1'b0, tx_ready = 1'b0;
  logic [1:0] reg_addr = 2'h0, set_nak = 2'h0;
  logic [7:0] reg_wdata = 8'h00, rx_data = 8'h00;
  logic [6:0] set_cnt = 7'h00;
  logic [7:0] reg_rdata_q, tx_data_q, buf_wr_data_q, buf_rd_data;
  logic rx_ready_q, tx_valid_q, x_nak, y_nak, buf_wr_en_q, buf_rd_en_q, buf_sel_q;
  logic desc_upd_q, desc_sel_q, desc_nak_q, irq_q;
  logic [6:0] x_count, y_count, desc_count_q;
  logic [5:0] buf_addr_q;
  logic [7:0] txq [$];
  int n_fail = 0, n_compared = 0, n_irq = 0;
  bdtc_channel dut_u (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
    .dir_in, .sof_pulse, .rx_valid, .rx_data, .rx_error, .rx_ready_q, .tx_valid_q, .tx_data_q,
    .tx_ready, .x_nak, .y_nak, .x_count, .y_count, .buf_wr_en_q, .buf_rd_en_q, .buf_sel_q,
    .buf_addr_q, .buf_wr_data_q, .buf_rd_data, .desc_upd_q, .desc_sel_q, .desc_count_q,
    .desc_nak_q, .edb_ptr_q(), .irq_q);
  bdtc_buf_model bm_u (.clk, .srst, .wr_en(buf_wr_en_q), .rd_en(buf_rd_en_q), .sel(buf_sel_q),
    .addr(buf_addr_q), .wr_data(buf_wr_data_q), .rd_data(buf_rd_data), .upd(desc_upd_q),
    .dsel(desc_sel_q), .dcount(desc_count_q), .dnak(desc_nak_q), .set_nak, .set_cnt, .x_nak,
    .y_nak, .x_count, .y_count);
  always #2 clk = ~clk;
  always @(posedge clk) tx_ready <= ~tx_ready;
  always @(posedge clk) if (irq_q === 1'b1) n_irq++;
  always @(posedge clk) if (tx_valid_q === 1'b1 && tx_ready) txq.push_back(tx_data_q);
  task wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [1:0] a, input logic [7:0] e);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    `CHK("register read", e, reg_rdata_q)
  endtask
  task free(input logic [1:0] m);
    set_nak <= m;
    @(posedge clk);
    set_nak <= 2'h0;
  endtask
  task feed(input logic [7:0] v0, input int n);
    for (int k = 0; k < n; k++) begin
      rx_valid <= 1'b1; rx_data <= v0 + k[7:0];
      @(posedge clk);
      while (rx_ready_q !== 1'b1) @(posedge clk);
    end
    rx_valid <= 1'b0;
  endtask
  task sof(input int n);
    repeat (n) begin
      sof_pulse <= 1'b1;
      @(posedge clk);
      sof_pulse <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  task print_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    print_verdict;
  end
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(2'h0, 8'h00);
    rd(2'h3, 8'h00);
    wr(2'h0, 8'h88);
    rd(2'h0, 8'h88);
    free(2'h3);
    wr(2'h1, 8'hE0);
    feed(8'h00, 67);
    `CHK("x last byte", 8'h3F, bm_u.mem[0][63])
    `CHK("x nak", 1'b0, x_nak)
    sof(1);
    rd(2'h0, 8'h88);
    sof(1);
    rd(2'h0, 8'h8A);
    rd(2'h2, 8'h00);
    `CHK("y count", 7'h03, y_count)
    `CHK("y nak", 1'b0, y_nak)
    `CHK("irq count", 1, n_irq)
    wr(2'h0, 8'h88);
    rd(2'h0, 8'h8A);
    wr(2'h0, 8'h8A);
    rd(2'h0, 8'h88);
    free(2'h1);
    wr(2'h1, 8'hE0);
    feed(8'h40, 64);
    sof(2);
    rd(2'h0, 8'h8A);
    rd(2'h2, 8'h01);
    `CHK("irq count", 2, n_irq)
    dir_in <= 1'b0;
    set_cnt <= 7'h05;
    free(2'h1);
    wr(2'h1, 8'hE0);
    for (int k = 0; k < 300 && txq.size() < 5; k++) @(posedge clk);
    repeat (6) @(posedge clk);
    `CHK("tx bytes", 5, txq.size())
    foreach (txq[i]) `CHK("tx byte", 8'h40 + i[7:0], txq[i])
    rd(2'h2, 8'h02);
    rd(2'h0, 8'h88);
    `CHK("x nak", 1'b0, x_nak)
    `CHK("irq count", 3, n_irq)
    dir_in <= 1'b1;
    wr(2'h0, 8'h08);
    free(2'h3);
    wr(2'h1, 8'hE0);
    feed(8'h00, 1);
    sof(3);
    rd(2'h0, 8'h08);
    `CHK("irq count", 3, n_irq)
    wr(2'h1, 8'h60);
    rd(2'h1, 8'h60);
    `CHK("irq count", 4, n_irq)
    wr(2'h1, 8'hE0);
    repeat (2) @(posedge clk);
    rx_error <= 1'b1;
    @(posedge clk);
    rx_error <= 1'b0;
    rd(2'h0, 8'h0A);
    rd(2'h1, 8'hE0);
    rd(2'h2, 8'h00);
    `CHK("irq count", 4, n_irq)
    print_verdict;
  end
endmodule
`default_nettype wire
